// >>> verilog/wscr_pkg.sv
// Constants for the wake source control register bank.
// Assumes a 16-bit SPI frame: 7 address bits, R/W bit, 8 data bits.
// Overview of operation
// (RL1) Internal bit 7 enables cyclic timer B wake
// (RL2) Internal bit 6 enables cyclic timer A wake
// (RL3) Reserved bits always read back as zero
// (RL4) Internal bit 2 stops watchdog in stop mode
// (RL5) Global interrupt clear: only wakes raise interrupt
// (RL6) Global interrupt set: any status bit interrupts
// (RL7) Select bit clear: pins one, two wake
// (RL8) Select bit set: pins one, two never wake
// (RL9) Measurement runs only in normal mode
// (RL10) Host ignores pin one, two levels measuring
// (RL11) External bit 2 enables wake pin three
// (RL12) External bit 1 enables wake pin two
// (RL13) External bit 0 enables wake pin one
// (RL14) Host sets bus wake in bus registers
// (RL15) Fail-safe entry forces fixed wake configuration
// (RL16) Pull codes: none, down, up, automatic
// (RL17) Pull fields: pin three 5:4, two 3:2, one 1:0
// (RL18) External resets 0x07; restart clears 6,4,3
// (RL19) Stop mode ignores peak bit writes silently
// (RL20) Reserved bit writes have no effect
package wscr_pkg;
  // Register addresses
  localparam logic [6:0] ADDR_BUS_CTRL_B = 7'h05;
  localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
  localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
  localparam logic [6:0] ADDR_PULL = 7'h08;
  // Field positions
  localparam int TIMER_B_EN_BIT = 7;
  localparam int TIMER_A_EN_BIT = 6;
  localparam int WDOG_STOP_OFF_BIT = 2;
  localparam int INT_GLOBAL_BIT = 7;
  localparam int MEASURE_SEL_BIT = 5;
  localparam int PIN_THREE_EN_BIT = 2;
  localparam int PIN_TWO_EN_BIT = 1;
  localparam int PIN_ONE_EN_BIT = 0;
  localparam int PEAK_THRESHOLD_BIT = 5;
  // Reset values and writable masks
  localparam logic [7:0] INT_WAKE_RESET = 8'h00;
  localparam logic [7:0] EXT_WAKE_RESET = 8'h07;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] INT_WAKE_MASK = 8'hC4;
  localparam logic [7:0] EXT_WAKE_MASK = 8'hA7;
  localparam logic [7:0] PULL_MASK = 8'h3F;
  // Restart keeps bits 7, 5, 2:0; fail-safe keeps 7, 5 and sets 2:0
  localparam logic [7:0] EXT_RESTART_KEEP = 8'hA7;
  localparam logic [7:0] EXT_FAILSAFE_KEEP = 8'hA0;
  localparam logic [7:0] EXT_FAILSAFE_SET = 8'h07;
  // Pull codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam int PULL_FIELD_W = 2;
  localparam int WAKE_PINS = 3;
  // Wake source indices; pins one and two yield to measurement
  localparam int WAKE_SOURCES = 5;
  localparam int SRC_PIN_ONE = 0;
  localparam int SRC_PIN_TWO = 1;
  localparam int SRC_PIN_THREE = 2;
  localparam int SRC_TIMER_A = 3;
  localparam int SRC_TIMER_B = 4;
  localparam logic [4:0] MEASURE_OVERRIDE = 5'h03;
  // Frame layout
  localparam logic [4:0] HEAD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] COUNT_MAX = 5'h1F;
  // SPI frame states
  typedef enum logic [2:0] {
    SPI_IDLE = 3'h1,
    SPI_HEAD = 3'h2,
    SPI_BODY = 3'h4
  } wscr_spi_e;
endpackage

// >>> verilog/wscr_wake_if.sv
// Interface between the register bank and the wake source gate.
// Assumes both ends sit in the ref_clk domain.
`timescale 1ns/1ps
interface wscr_wake_if;
  logic [4:0] sourceEnable;
  logic [4:0] sourceEvent;
  logic measureSelect;
  logic wakeAny;
  modport gate (
    input sourceEnable,
    input sourceEvent,
    input measureSelect,
    output wakeAny
  );
  modport bank (
    output sourceEnable,
    output sourceEvent,
    output measureSelect,
    input wakeAny
  );
endinterface

// >>> verilog/wscr_wake_gate.sv
// Combines filtered wake events with their enables.
// Assumes events are single-cycle pulses already filtered upstream.
`timescale 1ns/1ps
module wscr_wake_gate (
  wscr_wake_if.gate wakeBus
);
  logic [4:0] sourceHit;

  // One gate per source; measurement masks pins one and two
  genvar i;
  generate
    for (i = 0; i < wscr_pkg::WAKE_SOURCES; i++) begin : g_src
      assign sourceHit[i] = wakeBus.sourceEvent[i] & wakeBus.sourceEnable[i]
        & ~(wakeBus.measureSelect & wscr_pkg::MEASURE_OVERRIDE[i]); // RL8
    end
  endgenerate

  assign wakeBus.wakeAny = |sourceHit; // RL7
endmodule

// >>> verilog/wscr_pull_decode.sv
// Decodes the wake pin pull field into resistor controls.
// Assumes the analog pad acts on these levels directly.
`timescale 1ns/1ps
module wscr_pull_decode (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] pullField,
  output logic [2:0] pullUpEn,
  output logic [2:0] pullDownEn,
  output logic [2:0] pullAutoEn
);
  // One decoder per pin; registered so pads see no glitches
  genvar p;
  generate
    for (p = 0; p < wscr_pkg::WAKE_PINS; p++) begin : g_pin
      logic [1:0] code;
      assign code = pullField[p*wscr_pkg::PULL_FIELD_W +: wscr_pkg::PULL_FIELD_W]; // RL17
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          pullUpEn[p] <= 1'b0;
          pullDownEn[p] <= 1'b0;
          pullAutoEn[p] <= 1'b0;
        end else begin
          pullUpEn[p] <= (code == wscr_pkg::PULL_UP); // RL16
          pullDownEn[p] <= (code == wscr_pkg::PULL_DOWN); // RL16
          pullAutoEn[p] <= (code == wscr_pkg::PULL_AUTO); // RL16
        end
      end
    end
  endgenerate
endmodule

// >>> verilog/wscr_top.sv
// Wake source control register bank with its 16-bit SPI slave.
// Assumes SPI pins and mode inputs are synchronous to ref_clk.
`timescale 1ns/1ps
module wscr_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiSdi,
  input wire logic softReset,
  input wire logic restartEntry,
  input wire logic failSafeEntry,
  input wire logic stopMode,
  input wire logic normalMode,
  input wire logic timerAEvent,
  input wire logic timerBEvent,
  input wire logic pinOneEvent,
  input wire logic pinTwoEvent,
  input wire logic pinThreeEvent,
  input wire logic statusBitSet,
  output logic spiSdo,
  output logic spiSdoEn,
  output logic spiFail,
  output logic wakeEvent,
  output logic intRequest,
  output logic watchdogStopHalt,
  output logic measureActive,
  output logic busCtrlForce,
  output logic peakThreshold,
  output logic [2:0] pullUpEn,
  output logic [2:0] pullDownEn,
  output logic [2:0] pullAutoEn
);
  wscr_pkg::wscr_spi_e state_reg;
  logic [7:0] intWake_reg;
  logic [7:0] extWake_reg;
  logic [7:0] pullCtl_reg;
  logic [15:0] shiftIn_reg;
  logic [7:0] outShift_reg;
  logic [4:0] bitCount_reg;
  logic [6:0] addr_reg;
  logic writeFlag_reg;
  logic sclkPrev_reg;
  logic csnPrev_reg;
  logic sclkRise;
  logic sclkFall;
  logic csnFall;
  logic csnRise;
  logic frameOk;
  logic commit;
  logic headDone;
  logic [7:0] header;
  logic [7:0] readData;
  logic [7:0] writeData;

  wscr_wake_if wakeBus ();

  // Edge detection on the sampled SPI pins
  assign sclkRise = spiSclk & ~sclkPrev_reg;
  assign sclkFall = ~spiSclk & sclkPrev_reg;
  assign csnFall = csnPrev_reg & ~spiCsN;
  assign csnRise = ~csnPrev_reg & spiCsN;
  assign header = {shiftIn_reg[6:0], spiSdi};
  assign headDone = sclkRise && (state_reg == wscr_pkg::SPI_HEAD)
    && (bitCount_reg == wscr_pkg::HEAD_BITS - 5'h01);
  assign frameOk = (bitCount_reg == wscr_pkg::FRAME_BITS);
  assign commit = csnRise && (state_reg == wscr_pkg::SPI_BODY) && frameOk && writeFlag_reg;
  assign writeData = shiftIn_reg[7:0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkPrev_reg <= 1'b0;
      csnPrev_reg <= 1'b1;
    end else begin
      sclkPrev_reg <= spiSclk;
      csnPrev_reg <= spiCsN;
    end
  end

  // Frame state: header byte, then data byte
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= wscr_pkg::SPI_IDLE;
    end else if (spiCsN) begin
      state_reg <= wscr_pkg::SPI_IDLE;
    end else begin
      unique case (state_reg)
        wscr_pkg::SPI_IDLE: begin
          if (csnFall) begin
            state_reg <= wscr_pkg::SPI_HEAD;
          end
        end
        wscr_pkg::SPI_HEAD: begin
          if (headDone) begin
            state_reg <= wscr_pkg::SPI_BODY;
          end
        end
        wscr_pkg::SPI_BODY: begin
          state_reg <= wscr_pkg::SPI_BODY;
        end
      endcase
    end
  end

  // Bit counter saturates so overlong frames still count as bad
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCount_reg <= 5'h00;
      shiftIn_reg <= 16'h0000;
    end else if (csnFall) begin
      bitCount_reg <= 5'h00;
    end else if (sclkRise && !spiCsN) begin
      shiftIn_reg <= {shiftIn_reg[14:0], spiSdi};
      if (bitCount_reg != wscr_pkg::COUNT_MAX) begin
        bitCount_reg <= bitCount_reg + 5'h01;
      end
    end
  end

  // Latch address and direction at the end of the header
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= 7'h00;
      writeFlag_reg <= 1'b0;
    end else if (headDone) begin
      addr_reg <= header[7:1];
      writeFlag_reg <= header[0];
    end
  end

  // Read mux; stored bits are masked so reserved bits read zero
  always_comb begin
    unique case (header[7:1])
      wscr_pkg::ADDR_INT_WAKE: readData = intWake_reg & wscr_pkg::INT_WAKE_MASK; // RL3
      wscr_pkg::ADDR_EXT_WAKE: readData = extWake_reg & wscr_pkg::EXT_WAKE_MASK; // RL3
      wscr_pkg::ADDR_PULL: readData = pullCtl_reg & wscr_pkg::PULL_MASK; // RL3
      default: readData = 8'h00;
    endcase
  end

  // Serial out: first data bit at header end, rest on falling SCLK
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      outShift_reg <= 8'h00;
      spiSdo <= 1'b0;
      spiSdoEn <= 1'b0;
    end else begin
      spiSdoEn <= ~spiCsN;
      if (spiCsN) begin
        spiSdo <= 1'b0;
      end else if (headDone) begin
        spiSdo <= readData[7];
        outShift_reg <= {readData[6:0], 1'b0};
      end else if (sclkFall && state_reg == wscr_pkg::SPI_BODY
                   && bitCount_reg != wscr_pkg::HEAD_BITS) begin
        spiSdo <= outShift_reg[7];
        outShift_reg <= {outShift_reg[6:0], 1'b0};
      end
    end
  end

  // Frame length error flag, one cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      spiFail <= 1'b0;
    end else begin
      spiFail <= csnRise && (state_reg != wscr_pkg::SPI_IDLE) && !frameOk;
    end
  end

  // Internal wake control; restart leaves it alone
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      intWake_reg <= wscr_pkg::INT_WAKE_RESET;
    end else if (softReset) begin
      intWake_reg <= wscr_pkg::INT_WAKE_RESET;
    end else if (commit && addr_reg == wscr_pkg::ADDR_INT_WAKE) begin
      intWake_reg <= writeData & wscr_pkg::INT_WAKE_MASK; // RL20
    end
  end

  // External wake control; fail-safe outranks soft reset, restart and writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      extWake_reg <= wscr_pkg::EXT_WAKE_RESET; // RL18
    end else if (failSafeEntry) begin
      extWake_reg <= (extWake_reg & wscr_pkg::EXT_FAILSAFE_KEEP)
        | wscr_pkg::EXT_FAILSAFE_SET; // RL15
    end else if (softReset) begin
      extWake_reg <= wscr_pkg::EXT_WAKE_RESET; // RL18
    end else if (restartEntry) begin
      extWake_reg <= extWake_reg & wscr_pkg::EXT_RESTART_KEEP; // RL18
    end else if (commit && addr_reg == wscr_pkg::ADDR_EXT_WAKE) begin
      extWake_reg <= writeData & wscr_pkg::EXT_WAKE_MASK; // RL20
    end
  end

  // Pull control; kept through restart since reserved bits are zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pullCtl_reg <= wscr_pkg::PULL_RESET;
    end else if (softReset) begin
      pullCtl_reg <= wscr_pkg::PULL_RESET;
    end else if (commit && addr_reg == wscr_pkg::ADDR_PULL) begin
      pullCtl_reg <= writeData & wscr_pkg::PULL_MASK; // RL20
    end
  end

  // Peak threshold: read-only in stop mode, with no fail flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      peakThreshold <= 1'b0;
    end else if (failSafeEntry || softReset) begin
      peakThreshold <= 1'b0; // RL15
    end else if (commit && addr_reg == wscr_pkg::ADDR_BUS_CTRL_B && !stopMode) begin
      peakThreshold <= writeData[wscr_pkg::PEAK_THRESHOLD_BIT]; // RL19
    end
  end

  // Tell bus control logic to load its wake patterns
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busCtrlForce <= 1'b0;
    end else begin
      busCtrlForce <= failSafeEntry; // RL15
    end
  end

  // Wake source gating
  assign wakeBus.sourceEnable = {
    intWake_reg[wscr_pkg::TIMER_B_EN_BIT], // RL1
    intWake_reg[wscr_pkg::TIMER_A_EN_BIT], // RL2
    extWake_reg[wscr_pkg::PIN_THREE_EN_BIT], // RL11
    extWake_reg[wscr_pkg::PIN_TWO_EN_BIT], // RL12
    extWake_reg[wscr_pkg::PIN_ONE_EN_BIT] // RL13
  };
  assign wakeBus.sourceEvent = {timerBEvent, timerAEvent, pinThreeEvent, pinTwoEvent,
    pinOneEvent};
  assign wakeBus.measureSelect = extWake_reg[wscr_pkg::MEASURE_SEL_BIT];

  wscr_wake_gate u_gate (
    .wakeBus(wakeBus.gate)
  );

  // Wake, interrupt and mode outputs, all registered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeEvent <= 1'b0;
      intRequest <= 1'b0;
      watchdogStopHalt <= 1'b0;
      measureActive <= 1'b0;
    end else begin
      wakeEvent <= wakeBus.wakeAny;
      intRequest <= wakeBus.wakeAny
        | (extWake_reg[wscr_pkg::INT_GLOBAL_BIT] & statusBitSet); // RL5 RL6
      watchdogStopHalt <= stopMode & intWake_reg[wscr_pkg::WDOG_STOP_OFF_BIT]; // RL4
      measureActive <= normalMode & extWake_reg[wscr_pkg::MEASURE_SEL_BIT]; // RL9
    end
  end

  wscr_pull_decode u_pull (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pullField(pullCtl_reg[5:0]),
    .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn),
    .pullAutoEn(pullAutoEn)
  );

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic otherEvents;
  assign otherEvents = pinOneEvent | pinTwoEvent | pinThreeEvent | timerAEvent | timerBEvent;

  sequence s_stopPeakWrite;
    commit && addr_reg == wscr_pkg::ADDR_BUS_CTRL_B && stopMode;
  endsequence

  property p_timerBWake;
    timerBEvent && intWake_reg[wscr_pkg::TIMER_B_EN_BIT] |=> wakeEvent && intRequest;
  endproperty
  a_timerBWake: assert property (p_timerBWake) else $error("timer B wake lost"); // RL1

  property p_timerAMuted;
    timerAEvent && !intWake_reg[wscr_pkg::TIMER_A_EN_BIT]
      && !(otherEvents & ~timerAEvent) |=> !wakeEvent;
  endproperty
  a_timerAMuted: assert property (p_timerAMuted) else $error("disabled timer A woke"); // RL2

  property p_reservedZero;
    (intWake_reg & ~wscr_pkg::INT_WAKE_MASK) == 8'h00
      && (extWake_reg & ~wscr_pkg::EXT_WAKE_MASK) == 8'h00
      && (pullCtl_reg & ~wscr_pkg::PULL_MASK) == 8'h00;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bit stored"); // RL3

  property p_watchdogHalt;
    ##1 watchdogStopHalt == $past(stopMode && intWake_reg[wscr_pkg::WDOG_STOP_OFF_BIT]);
  endproperty
  a_watchdogHalt: assert property (p_watchdogHalt) else $error("watchdog halt wrong"); // RL4

  property p_localInt;
    !extWake_reg[wscr_pkg::INT_GLOBAL_BIT] && statusBitSet && !wakeBus.wakeAny |=> !intRequest;
  endproperty
  a_localInt: assert property (p_localInt) else $error("status interrupt leaked"); // RL5

  property p_globalInt;
    extWake_reg[wscr_pkg::INT_GLOBAL_BIT] && statusBitSet |=> intRequest;
  endproperty
  a_globalInt: assert property (p_globalInt) else $error("global interrupt missing"); // RL6

  property p_measureMasks;
    extWake_reg[wscr_pkg::MEASURE_SEL_BIT] && (pinOneEvent || pinTwoEvent)
      && !pinThreeEvent && !timerAEvent && !timerBEvent |=> !wakeEvent;
  endproperty
  a_measureMasks: assert property (p_measureMasks) else $error("pin woke while measuring"); // RL8

  property p_failSafe;
    failSafeEntry |=> extWake_reg[2:0] == 3'h7 && extWake_reg[6] == 1'b0 && busCtrlForce
      && extWake_reg[7] == $past(extWake_reg[7]) && !peakThreshold;
  endproperty
  a_failSafe: assert property (p_failSafe) else $error("fail-safe pattern wrong"); // RL15

  property p_restart;
    restartEntry && !failSafeEntry && !softReset
      |=> extWake_reg == ($past(extWake_reg) & wscr_pkg::EXT_RESTART_KEEP);
  endproperty
  a_restart: assert property (p_restart) else $error("restart value wrong"); // RL18

  property p_stopPeak;
    s_stopPeakWrite and !failSafeEntry and !softReset |=> $stable(peakThreshold) && !spiFail;
  endproperty
  a_stopPeak: assert property (p_stopPeak) else $error("stop mode peak write acted"); // RL19
endmodule

// >>> bench/wscr_spi_host.sv
// Host controller model acting as master of the bank's 16-bit serial port.
// Assumes ref_clk paces everything; pins move 1 ns after a rising edge.
`timescale 1ns/1ps
module wscr_spi_host (
  input wire logic ref_clk,
  output logic spiCsN,
  output logic spiSclk,
  output logic spiSdi,
  input wire logic spiSdo
);
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiSdi = 1'b0;
  end
  // One frame, MSB first; half is the SCLK half period in clocks (2 or more)
  task automatic frame(input logic [15:0] word, input int bits, input int half,
                       output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk);
    #1 spiCsN = 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < bits; i++) begin
      #1 spiSclk = 1'b0;
      spiSdi = word[15-i];
      repeat (half) @(posedge ref_clk);
      // Sample just before the rise, long after the answer has settled
      #1 if (i >= 8) rd[15-i] = spiSdo;
      spiSclk = 1'b1;
      repeat (half) @(posedge ref_clk);
    end
    // Data line released: show the inverse so a stale level never passes
    #1 spiSclk = 1'b0;
    spiSdi = ~spiSdi;
    repeat (half) @(posedge ref_clk);
    #1 spiCsN = 1'b1;
    repeat (3) @(posedge ref_clk);
    // Return just after an edge so the caller's next change never races it
    #1;
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the wake source control register bank.
// Assumes the host model drives the serial pins; all else is driven here.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic [8:0] p;
  } wscr_row_s;
  // Write data, expected readback, expected pull outputs {up, down, auto}
  localparam wscr_row_s ROWS [7] = '{
    '{7'h06, 8'hFF, 8'hC4, 9'h000}, '{7'h07, 8'hFF, 8'hA7, 9'h000},
    '{7'h05, 8'hFF, 8'h00, 9'h000}, '{7'h09, 8'hFF, 8'h00, 9'h000},
    '{7'h08, 8'hFF, 8'h3F, 9'h007}, '{7'h08, 8'h1B, 8'h1B, 9'h0A1},
    '{7'h08, 8'hE4, 8'h24, 9'h110}};
  // Internal, external pairs for the wake gating table
  localparam logic [15:0] WAKES [5] = '{16'h0007, 16'hC000, 16'h4025, 16'h8022, 16'h0003};
  logic ref_clk, reset_n, spiCsN, spiSclk, spiSdi, spiSdo;
  logic softReset, restartEntry, failSafeEntry, stopMode, normalMode, statusBitSet;
  logic spiSdoEn, spiFail, wakeEvent, intRequest, watchdogStopHalt, measureActive;
  logic busCtrlForce, peakThreshold;
  logic [2:0] pullUpEn, pullDownEn, pullAutoEn;
  logic [4:0] evt, en;
  logic [7:0] rd;
  int fails, checked, failPulses, csnLow, sdoOn;
  wscr_spi_host host (.ref_clk(ref_clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiSdi(spiSdi), .spiSdo(spiSdo));
  wscr_top u_wscr_top (.ref_clk(ref_clk), .reset_n(reset_n), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiSdi(spiSdi), .softReset(softReset),
    .restartEntry(restartEntry), .failSafeEntry(failSafeEntry), .stopMode(stopMode),
    .normalMode(normalMode), .timerAEvent(evt[3]), .timerBEvent(evt[4]),
    .pinOneEvent(evt[0]), .pinTwoEvent(evt[1]), .pinThreeEvent(evt[2]),
    .statusBitSet(statusBitSet), .spiSdo(spiSdo), .spiSdoEn(spiSdoEn),
    .spiFail(spiFail), .wakeEvent(wakeEvent), .intRequest(intRequest),
    .watchdogStopHalt(watchdogStopHalt), .measureActive(measureActive),
    .busCtrlForce(busCtrlForce), .peakThreshold(peakThreshold),
    .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .pullAutoEn(pullAutoEn));
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Counts fail pulses and driven cycles mid-cycle, where outputs have settled
  always @(negedge ref_clk) begin
    if (spiFail === 1'b1) failPulses++;
    if (spiCsN === 1'b0) csnLow++;
    if (spiSdoEn === 1'b1) sdoOn++;
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({a, 1'b1, d}, 16, 2, rd);
  endtask
  // Reads use a slower serial clock than writes
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    host.frame({a, 1'b0, 8'h00}, 16, 3, rd);
    chk(rd, exp);
    // Data out is driven one cycle late for exactly as long as select is low
    chk(9'(sdoOn - csnLow), 9'h000);
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is about 100 us; this leaves wide margin for a hang
  initial begin
    #2ms;
    fails++;
    stop_test();
  end
  initial begin
    reset_n = 1'b0;
    {softReset, restartEntry, failSafeEntry, stopMode, statusBitSet} = 5'h00;
    normalMode = 1'b1;
    evt = 5'h00;
    fails = 0;
    checked = 0;
    failPulses = 0;
    repeat (4) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    chk({wakeEvent, intRequest, busCtrlForce, peakThreshold, measureActive}, 9'h000);
    rdchk(wscr_pkg::ADDR_INT_WAKE, 8'h00);
    rdchk(wscr_pkg::ADDR_EXT_WAKE, 8'h07);
    rdchk(wscr_pkg::ADDR_PULL, 8'h00);
    // Ordinary register rows: reserved bits, unmapped place, all pull codes
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rdchk(ROWS[i].a, ROWS[i].r);
      chk({pullUpEn, pullDownEn, pullAutoEn}, ROWS[i].p);
    end
    chk(peakThreshold, 9'h001);
    // Wake gating; bus wake is never set here, it lives in the bus registers
    foreach (WAKES[k]) begin
      wr(wscr_pkg::ADDR_INT_WAKE, WAKES[k][15:8]);
      wr(wscr_pkg::ADDR_EXT_WAKE, WAKES[k][7:0]);
      en = {WAKES[k][15], WAKES[k][14], WAKES[k][2], WAKES[k][1:0] & ~{2{WAKES[k][5]}}};
      chk(measureActive, 9'(WAKES[k][5]));
      for (int i = 0; i < 5; i++) begin
        evt = 5'h01 << i;
        tick();
        chk(wakeEvent, 9'(en[i]));
        chk(intRequest, 9'(en[i]));
        evt = 5'h00;
        tick();
      end
    end
    // Measurement output only in normal mode; pin levels ignored meanwhile
    wr(wscr_pkg::ADDR_EXT_WAKE, 8'h20);
    normalMode = 1'b0;
    tick();
    tick();
    chk(measureActive, 9'h000);
    normalMode = 1'b1;
    // Status bits interrupt only with the global bit set
    for (int g = 0; g < 2; g++) begin
      wr(wscr_pkg::ADDR_EXT_WAKE, {g[0], 7'h03});
      statusBitSet = 1'b1;
      tick();
      chk({wakeEvent, intRequest}, 9'(g));
      statusBitSet = 1'b0;
      tick();
    end
    // Watchdog halt in stop mode, and peak bit frozen there
    wr(wscr_pkg::ADDR_INT_WAKE, 8'h04);
    stopMode = 1'b1;
    tick();
    tick();
    chk(watchdogStopHalt, 9'h001);
    wr(wscr_pkg::ADDR_BUS_CTRL_B, 8'h00);
    chk(peakThreshold, 9'h001);
    chk(9'(failPulses), 9'h000);
    wr(wscr_pkg::ADDR_INT_WAKE, 8'h00);
    chk(watchdogStopHalt, 9'h000);
    stopMode = 1'b0;
    // Short frame is refused and flagged
    host.frame({wscr_pkg::ADDR_EXT_WAKE, 1'b1, 8'h00}, 15, 2, rd);
    chk(9'(failPulses), 9'h001);
    rdchk(wscr_pkg::ADDR_EXT_WAKE, 8'h83);
    // Restart keeps the writable external bits
    wr(wscr_pkg::ADDR_EXT_WAKE, 8'hFF);
    restartEntry = 1'b1;
    tick();
    restartEntry = 1'b0;
    rdchk(wscr_pkg::ADDR_EXT_WAKE, 8'hA7);
    // Fail-safe forces the wake pins on and keeps bits 7 and 5
    wr(wscr_pkg::ADDR_EXT_WAKE, 8'h20);
    wr(wscr_pkg::ADDR_BUS_CTRL_B, 8'h20);
    failSafeEntry = 1'b1;
    tick();
    chk(busCtrlForce, 9'h001);
    failSafeEntry = 1'b0;
    tick();
    chk({busCtrlForce, peakThreshold}, 9'h000);
    rdchk(wscr_pkg::ADDR_EXT_WAKE, 8'h27);
    // Soft reset restores the power-on values
    wr(wscr_pkg::ADDR_INT_WAKE, 8'hC4);
    softReset = 1'b1;
    tick();
    softReset = 1'b0;
    rdchk(wscr_pkg::ADDR_INT_WAKE, 8'h00);
    rdchk(wscr_pkg::ADDR_EXT_WAKE, 8'h07);
    rdchk(wscr_pkg::ADDR_PULL, 8'h00);
    chk({pullUpEn, pullDownEn, pullAutoEn}, 9'h000);
    // Reset in mid-run brings every register back to its power-on value
    wr(wscr_pkg::ADDR_EXT_WAKE, 8'h80);
    wr(wscr_pkg::ADDR_PULL, 8'h3F);
    reset_n = 1'b0;
    tick();
    tick();
    reset_n = 1'b1;
    chk({pullUpEn, pullDownEn, pullAutoEn}, 9'h000);
    rdchk(wscr_pkg::ADDR_EXT_WAKE, 8'h07);
    rdchk(wscr_pkg::ADDR_PULL, 8'h00);
    stop_test();
  end
endmodule
